// ==== ced_pkg.sv ====
/*
  package for the crc error detect readout block: widths, reset values, divider
  limits, the core_clk-domain error-check states and the carrier structs.
  assumes nothing beyond a systemverilog compiler.
*/
package ced_pkg;

  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int CED_CRC_W = 32;
  localparam logic [31:0] CED_SHIFT_RST = 32'h0000_0000;
  localparam logic [31:0] CED_PRECOMP_RST = 32'h0000_0000;
  localparam logic [31:0] CED_SIG_RST = 32'h0000_0000;

  // ----------------------------------------
  // error-check clock divider
  // ----------------------------------------
  localparam int CED_DIV_MIN = 1;
  localparam int CED_DIV_MAX = 256;
  localparam int CED_DIV_W = 9;
  localparam logic [8:0] CED_DIV_RST = 9'h001;

  // ----------------------------------------
  // readout fifo
  // ----------------------------------------
  localparam int CED_FIFO_DEPTH = 4;

  // ----------------------------------------
  // error-check states
  // ----------------------------------------
  typedef enum logic [1:0] {
    CED_IDLE = 2'b00,
    CED_COMPARE = 2'b01,
    CED_ERROR = 2'b11
  } ced_state_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic shift_not_load;
    logic load_source_select;
  } ced_ctrl_t;

  typedef struct packed {
    logic [31:0] precomputed;
    logic [31:0] computed;
  } ced_crc_pair_t;

endpackage

// ==== ced_fifo.sv ====
/*
  small synchronous fifo with parameter width and depth, valid/ready both sides.
  assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
module ced_fifo import ced_pkg::*; #(
  parameter int WIDTH = 32,
  parameter int DEPTH = CED_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW-1:0] last_ptr = AW'(DEPTH - 1);

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // ----------------------------------------
  // storage and pointers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == last_ptr) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == last_ptr) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// ==== ced_readout.sv ====
/*
  crc error detect readout port: a 32-bit shift register that parallel loads
  the precomputed crc or the computed signature and shifts it out inverted,
  plus a mismatch flag timed by a divided oscillator tick.
  assumes a 10 mhz core_clk; the oscillator arrives as a one-cycle enable
  pulse already in this domain, and computed crc words arrive through a fifo.
*/
`timescale 1ns/100ps
module ced_readout import ced_pkg::*; #(
  parameter int CRC_W = CED_CRC_W,
  parameter int DEPTH = CED_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic shift_not_load,
  input wire logic load_source_select,
  output logic serial_readout,
  input wire logic osc_tick,
  input wire logic [8:0] osc_divisor,
  input wire logic [CRC_W-1:0] precomputed_crc,
  input wire logic [CRC_W-1:0] crc_word,
  input wire logic crc_word_valid,
  output logic crc_word_ready,
  output logic crc_mismatch_flag,
  output logic bidirectional_pin_out,
  output logic bidirectional_pin_oe_n
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  ced_ctrl_t ctrl_meta;
  ced_ctrl_t ctrl;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_meta <= '0;
      ctrl <= '0;
    end else begin
      ctrl_meta <= '{shift_not_load, load_source_select};
      ctrl <= ctrl_meta;
    end
  end

  // ----------------------------------------
  // computed crc words through the fifo
  // ----------------------------------------
  logic [CRC_W-1:0] fifo_data;
  logic fifo_valid;
  logic err_tick;
  ced_fifo #(
    .WIDTH(CRC_W),
    .DEPTH(DEPTH)
  ) ced_fifo_inst (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_data(crc_word),
    .in_valid(crc_word_valid),
    .in_ready(crc_word_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(err_tick)
  );

  // ----------------------------------------
  // error-check clock divider
  // ----------------------------------------
  logic [8:0] div_cnt;
  wire [8:0] div_lim = (osc_divisor == 9'h000) ? CED_DIV_RST :
    ((osc_divisor > 9'(CED_DIV_MAX)) ? 9'(CED_DIV_MAX) : osc_divisor);
  wire div_wrap = osc_tick && (div_cnt + 9'h001 >= div_lim);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= '0;
      err_tick <= 1'b0;
    end else begin
      err_tick <= div_wrap;
      if (div_wrap) begin
        div_cnt <= '0;
      end else if (osc_tick) begin
        div_cnt <= div_cnt + 9'h001;
      end
    end
  end

  // ----------------------------------------
  // signature register and mismatch check
  // ----------------------------------------
  ced_crc_pair_t crc;
  ced_state_t state;
  ced_state_t next_state;
  wire take = err_tick && fifo_valid;
  wire differs = (fifo_data != precomputed_crc);
  always_comb begin
    next_state = state;
    case (state)
      CED_IDLE: begin
        if (take) begin
          next_state = CED_COMPARE;
        end
      end
      CED_COMPARE: begin
        if (crc.computed != crc.precomputed) begin
          next_state = CED_ERROR;
        end else begin
          next_state = CED_IDLE;
        end
      end
      CED_ERROR: begin
        if (take && !differs) begin
          next_state = CED_IDLE;
        end
      end
      default: begin
        next_state = CED_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      crc <= '{CED_PRECOMP_RST, CED_SIG_RST};
      state <= CED_IDLE;
      crc_mismatch_flag <= 1'b0;
    end else begin
      state <= next_state;
      if (take) begin
        crc <= '{precomputed_crc, fifo_data};
      end
      if (err_tick || state == CED_COMPARE) begin
        crc_mismatch_flag <= (next_state == CED_ERROR);
      end
    end
  end

  assign bidirectional_pin_out = crc_mismatch_flag;
  assign bidirectional_pin_oe_n = 1'b0;

  // ----------------------------------------
  // readout shift register
  // ----------------------------------------
  logic [CRC_W-1:0] shreg;
  wire [CRC_W-1:0] load_val = ctrl.load_source_select ? crc.computed : precomputed_crc;
  wire [CRC_W-1:0] next_shreg = ctrl.shift_not_load ?
    {shreg[CRC_W-2:0], 1'b0} : load_val;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      shreg <= CED_SHIFT_RST;
    end else begin
      shreg <= next_shreg;
    end
  end

  assign serial_readout = ~shreg[CRC_W-1];

endmodule

// ==== ced_readout_monitor.sv ====
/* port checker for ced_readout; bound to every instance after the module */
`timescale 1ns/100ps
module ced_readout_monitor import ced_pkg::*; #(
  parameter int CRC_W = CED_CRC_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic shift_not_load,
  input wire logic load_source_select,
  input wire logic serial_readout,
  input wire logic osc_tick,
  input wire logic [CRC_W-1:0] precomputed_crc,
  input wire logic crc_word_ready,
  input wire logic crc_mismatch_flag,
  input wire logic bidirectional_pin_out,
  input wire logic bidirectional_pin_oe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [5:0] hi_cnt;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hi_cnt <= 6'h00;
    end else if (!shift_not_load) begin
      hi_cnt <= 6'h00;
    end else if (hi_cnt != 6'h3f) begin
      hi_cnt <= hi_cnt + 6'h01;
    end
  end
  sequence s_load_pre;
    (!shift_not_load && !load_source_select && $stable(precomputed_crc))[*4];
  endsequence
  property p_oe; bidirectional_pin_oe_n == 1'b0; endproperty
  property p_pin; bidirectional_pin_out == crc_mismatch_flag; endproperty
  property p_zeros; hi_cnt >= 6'h24 |-> serial_readout; endproperty
  property p_load_pre; s_load_pre |-> serial_readout == ~precomputed_crc[CRC_W-1]; endproperty
  property p_first_shift;
    s_load_pre ##1 shift_not_load[*3] |=> serial_readout == ~precomputed_crc[CRC_W-2];
  endproperty
  property p_flag_quiet; (!osc_tick)[*6] |=> $stable(crc_mismatch_flag); endproperty
  property p_reset_vals;
    $rose(nrst) |-> serial_readout && !crc_mismatch_flag && crc_word_ready;
  endproperty
  property p_ready_full; (!crc_word_ready && !osc_tick)[*3] |=> !crc_word_ready; endproperty
  a_oe: assert property (p_oe) else $error("pin enable off");
  a_pin: assert property (p_pin) else $error("pin differs from flag");
  a_zeros: assert property (p_zeros) else $error("drained shift not one");
  a_load_pre: assert property (p_load_pre) else $error("bad first bit");
  a_first_shift: assert property (p_first_shift) else $error("bad second bit");
  a_flag_quiet: assert property (p_flag_quiet) else $error("flag moved untimed");
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset outputs");
  a_ready_full: assert property (p_ready_full) else $error("full buffer freed");
endmodule
bind ced_readout ced_readout_monitor #(.CRC_W(CRC_W)) ced_readout_monitor_inst (.*);

// ==== ced_reader.sv ====
/* reader model of the core logic; drives the pins at the falling edge */
`timescale 1ns/100ps
module ced_reader (
  input wire logic core_clk,
  input wire logic serial_readout,
  output logic shift_not_load,
  output logic load_source_select
);
  initial begin
    shift_not_load = 1'b1;
    load_source_select = 1'b0;
  end
  task automatic read_word(input logic src, output logic [31:0] val);
    @(negedge core_clk);
    shift_not_load = 1'b0;
    load_source_select = src;
    repeat (4) @(negedge core_clk);
    val[31] = ~serial_readout;
    shift_not_load = 1'b1;
    load_source_select = ~src;
    repeat (2) @(negedge core_clk);
    for (int i = 30; i >= 0; i--) begin
      @(negedge core_clk);
      val[i] = ~serial_readout;
    end
  endtask
endmodule

// ==== ced_readout_test.sv ====
/* testbench for ced_readout; needs ced_reader and the bound monitor */
`timescale 1ns/100ps
module ced_readout_test;
  import ced_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic osc_tick = 1'b0;
  logic crc_word_valid = 1'b0;
  logic [8:0] osc_divisor = 9'h003;
  logic [31:0] precomputed_crc = 32'ha5c3_0f81;
  logic [31:0] crc_word = 32'h0000_0000;
  logic [31:0] got;
  logic shift_not_load, load_source_select, serial_readout, crc_word_ready;
  logic crc_mismatch_flag, bidirectional_pin_out, bidirectional_pin_oe_n;
  int n_errors = 0;
  int num_checks = 0;
  always #50 core_clk = ~core_clk;
  ced_readout ced_readout_inst (.*);
  ced_reader ced_reader_inst (.*);
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    num_checks++;
    if (act !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic push(input logic [31:0] w);
    @(negedge core_clk);
    crc_word = w;
    crc_word_valid = 1'b1;
    @(negedge core_clk);
    crc_word_valid = 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge core_clk);
      osc_tick = 1'b1;
      @(negedge core_clk);
      osc_tick = 1'b0;
    end
  endtask
  task automatic t_reset;
    chk({31'h0, serial_readout}, 32'h1);
    chk({31'h0, crc_mismatch_flag}, 32'h0);
    chk({31'h0, bidirectional_pin_oe_n}, 32'h0);
  endtask
  task automatic t_sig;
    for (int k = 0; k < 4; k++) push(k == 3 ? 32'h1234_5678 : 32'h0000_0100 + k);
    repeat (3) @(negedge core_clk);
    chk({31'h0, crc_word_ready}, 32'h0);
    ticks(20);
    repeat (8) @(negedge core_clk);
    chk({31'h0, crc_word_ready}, 32'h1);
    chk({31'h0, crc_mismatch_flag}, 32'h1);
    ced_reader_inst.read_word(1'b1, got);
    chk(got, 32'h1234_5678);
    push(precomputed_crc);
    ticks(5);
    repeat (8) @(negedge core_clk);
    chk({31'h0, bidirectional_pin_out}, 32'h0);
  endtask
  initial begin
    repeat (5) @(negedge core_clk);
    t_reset;
    nrst = 1'b1;
    ced_reader_inst.read_word(1'b0, got);
    chk(got, precomputed_crc);
    t_sig;
    repeat (40) @(negedge core_clk);
    chk({31'h0, serial_readout}, 32'h1);
    close_out;
  end
  initial begin
    #400000;
    n_errors++;
    close_out;
  end
endmodule
